// *** design/akb_pkg.sv ***
package akb_pkg;
  // ==========================================================
  // sizes
  localparam int PORT_N = 53;
  localparam int PORT_W = 6;
  localparam int MASK_W = 53;
  localparam int TAG_W = 8;
  localparam int WORD_W = 36;
  localparam int WORDS_FOUR = 4;
  localparam int WORDS_EIGHT = 8;
  localparam int WORDS_SIXTEEN = 16;
  localparam int KEY_W = WORDS_SIXTEEN * WORD_W;
  localparam int LEN_IPV4_VLAN = 88;
  localparam int LEN_SEVEN_FIELD = 567;
  localparam int LEN_CUSTOM_ONE = 546;
  // ==========================================================
  // key formats and selector codes
  typedef enum logic [3:0] {
    KF_IPV4_VLAN = 4'h0, KF_ETYPE = 4'h1, KF_ARP = 4'h2, KF_IPV4_TRANSPORT = 4'h3,
    KF_IPV4_MISC = 4'h4, KF_CUSTOM_TWO = 4'h5, KF_IPV6_VLAN = 4'h6,
    KF_SEVEN_FIELD = 4'h7, KF_CUSTOM_ONE = 4'h8
  } akb_fmt_t;
  typedef enum logic [1:0] {SZ_FOUR = 2'h0, SZ_EIGHT = 2'h1, SZ_SIXTEEN = 2'h2} akb_size_t;
  localparam logic [3:0] SEL8_ETYPE = 4'h0;
  localparam logic [3:0] SEL8_ARP = 4'h3;
  localparam logic [3:0] SEL8_IPV4_TRANSPORT = 4'h4;
  localparam logic [3:0] SEL8_IPV4_MISC = 4'h5;
  localparam logic [3:0] SEL8_CUSTOM_TWO = 4'h8;
  localparam logic [3:0] SEL8_IPV6_VLAN = 4'h9;
  localparam logic [1:0] SEL16_SEVEN_FIELD = 2'h1;
  localparam logic [1:0] SEL16_CUSTOM_ONE = 2'h2;
  // ==========================================================
  // field positions
  localparam int X4_FIRST = 0;
  localparam int X4_TAG_LSB = 1;
  localparam int X8_SEL_LSB = 0;
  localparam int X8_FIRST = 4;
  localparam int X8_TAG_LSB = 5;
  localparam int X8_MSEL_LSB = 13;
  localparam int X8_MASK_LSB = 15;
  localparam int X8_MC = 68;
  localparam int X16_SEL_LSB = 0;
  localparam int X16_FIRST = 2;
  localparam int X16_TAG_LSB = 3;
  localparam int X16_MSEL_LSB = 11;
  localparam int X16_MASK_LSB = 13;
  localparam int X16_MC = 66;
  localparam int M3_SRC_LSB = 4;
  localparam int M3_PT_LSB = 44;
  localparam int M3_ACT_LSB = 49;
  localparam int DMAC_MC_BIT = 40;
  localparam logic [1:0] MM_DEFAULT = 2'h0;
  localparam logic [1:0] MM_LOOP = 2'h1;
  localparam logic [1:0] MM_MASQ = 2'h2;
  localparam logic [1:0] MM_SPECIAL = 2'h3;
  // ==========================================================
  // registers
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TAG_IDX = 12'h008;
  localparam logic [11:0] REG_TAG_DATA = 12'h00c;
  localparam int CTRL_MASQ = 0;
  localparam int CTRL_INJ = 1;
  localparam int CTRL_VD = 2;
  localparam int CTRL_LBK3 = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [TAG_W-1:0] TAG_RST = 8'h00;
  // ==========================================================
  // carriers
  typedef struct packed {
    akb_fmt_t fmt;
    logic first_lookup;
    logic tag_changed;
    logic [TAG_W-1:0] tag;
    logic [PORT_W-1:0] phys_port;
    logic [PORT_W-1:0] src_port;
    logic [PORT_W-1:0] loop_port;
    logic dst_inject;
    logic cpu_injected;
    logic from_loopback;
    logic [4:0] pipe_pt;
    logic [2:0] pipe_act;
    logic [47:0] dmac;
  } akb_frame_t;
  typedef struct packed {
    logic valid;
    akb_size_t size;
    logic [KEY_W-1:0] data;
  } akb_key_t;
endpackage : akb_pkg

// *** design/akb_key_builder.sv ***
`timescale 1ns/1ps
`default_nettype none
module akb_key_builder #(
  parameter logic [5:0] PROC_PORT0 = 6'h35,
  parameter logic [5:0] PROC_PORT1 = 6'h36,
  parameter logic [5:0] VDEV_PORT0 = 6'h37,
  parameter logic [5:0] VDEV_PORT1 = 6'h38,
  parameter logic [2:0] MASQ_INJECT_ACT = 3'h1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // classification in
  input wire logic frame_valid,
  input wire akb_pkg::akb_frame_t frame_info,
  // key out
  output akb_pkg::akb_key_t key_out
);
  // ==========================================================
  // registers
  logic [3:0] ctrl_q;
  logic [akb_pkg::PORT_W-1:0] tag_idx_q;
  logic [15:0] key_cnt_q;
  logic [akb_pkg::TAG_W-1:0] port_tag_q [akb_pkg::PORT_N];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  akb_pkg::akb_key_t key_q;
  logic apb_setup;
  logic apb_wr;
  logic addr_ok;
  logic [31:0] rd_d;

  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite & pready_q;
  assign addr_ok = (paddr == akb_pkg::REG_CTRL) | (paddr == akb_pkg::REG_STATUS) |
                   (paddr == akb_pkg::REG_TAG_IDX) | (paddr == akb_pkg::REG_TAG_DATA);

  always_comb begin
    rd_d = 32'h0;
    unique case (paddr)
      akb_pkg::REG_CTRL: rd_d = {28'h0, ctrl_q};
      akb_pkg::REG_STATUS: rd_d = {16'h0, key_cnt_q};
      akb_pkg::REG_TAG_IDX: rd_d = {26'h0, tag_idx_q};
      akb_pkg::REG_TAG_DATA: begin
        if (32'(tag_idx_q) < akb_pkg::PORT_N) begin
          rd_d = {24'h0, port_tag_q[tag_idx_q]};
        end
      end
      default: rd_d = 32'h0;
    endcase
  end

  // zero-wait answer: ready in the access cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~addr_ok;
      if (apb_setup) begin
        prdata_q <= pwrite ? 32'h0 : rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= akb_pkg::CTRL_RST;
      tag_idx_q <= '0;
    end else if (apb_wr) begin
      if (paddr == akb_pkg::REG_CTRL) begin
        ctrl_q <= pwdata[3:0];
      end
      if (paddr == akb_pkg::REG_TAG_IDX) begin
        tag_idx_q <= pwdata[akb_pkg::PORT_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < akb_pkg::PORT_N; i++) begin
        port_tag_q[i] <= akb_pkg::TAG_RST;
      end
    end else if (apb_wr && paddr == akb_pkg::REG_TAG_DATA && 32'(tag_idx_q) < akb_pkg::PORT_N) begin
      port_tag_q[tag_idx_q] <= pwdata[akb_pkg::TAG_W-1:0];
    end
  end

  // ==========================================================
  // classification
  logic is_masq;
  logic is_vdev;
  logic [1:0] mode_d;
  logic [akb_pkg::TAG_W-1:0] tag_d;
  logic [akb_pkg::MASK_W-1:0] hot_phys;
  logic [akb_pkg::MASK_W-1:0] hot_loop;
  logic [akb_pkg::MASK_W-1:0] hot_src;
  logic [akb_pkg::MASK_W-1:0] mask_d;
  logic mc_d;

  assign is_masq = (frame_info.dst_inject && frame_info.src_port != frame_info.phys_port) ||
                   (frame_info.pipe_act == MASQ_INJECT_ACT);
  assign is_vdev = (frame_info.phys_port == VDEV_PORT0) || (frame_info.phys_port == VDEV_PORT1);
  assign mc_d = frame_info.dmac[akb_pkg::DMAC_MC_BIT];

  // highest qualifying mode wins
  always_comb begin
    if ((frame_info.cpu_injected && ctrl_q[akb_pkg::CTRL_INJ]) ||
        (is_vdev && ctrl_q[akb_pkg::CTRL_VD]) ||
        (frame_info.from_loopback && ctrl_q[akb_pkg::CTRL_LBK3])) begin
      mode_d = akb_pkg::MM_SPECIAL;
    end else if (is_masq && ctrl_q[akb_pkg::CTRL_MASQ]) begin
      mode_d = akb_pkg::MM_MASQ;
    end else if (frame_info.from_loopback) begin
      mode_d = akb_pkg::MM_LOOP;
    end else begin
      mode_d = akb_pkg::MM_DEFAULT;
    end
  end

  always_comb begin
    tag_d = frame_info.tag;
    if (!frame_info.tag_changed) begin
      tag_d = (32'(frame_info.phys_port) < akb_pkg::PORT_N) ? port_tag_q[frame_info.phys_port]
                                                             : akb_pkg::TAG_RST;
    end
  end

  for (genvar g = 0; g < akb_pkg::MASK_W; g++) begin : g_hot
    assign hot_phys[g] = (frame_info.phys_port == 6'(g));
    assign hot_loop[g] = (frame_info.loop_port == 6'(g));
    assign hot_src[g] = (frame_info.src_port == 6'(g));
  end

  always_comb begin
    mask_d = '0;
    unique case (mode_d)
      akb_pkg::MM_DEFAULT: mask_d = hot_phys;
      akb_pkg::MM_LOOP: mask_d = hot_loop;
      akb_pkg::MM_MASQ: mask_d = hot_src;
      akb_pkg::MM_SPECIAL: begin
        mask_d[0] = (frame_info.phys_port == PROC_PORT0);
        mask_d[1] = (frame_info.phys_port == PROC_PORT1);
        mask_d[2] = (frame_info.phys_port == VDEV_PORT0);
        mask_d[3] = (frame_info.phys_port == VDEV_PORT1);
        mask_d[akb_pkg::M3_SRC_LSB +: akb_pkg::PORT_W] = frame_info.src_port;
        mask_d[akb_pkg::M3_PT_LSB +: 5] = frame_info.pipe_pt;
        mask_d[akb_pkg::M3_ACT_LSB +: 3] = frame_info.pipe_act;
      end
    endcase
  end

  // ==========================================================
  // key packing, unused high bits stay zero
  akb_pkg::akb_key_t key_d;
  logic [3:0] sel8;
  logic [1:0] sel16;

  always_comb begin
    sel8 = akb_pkg::SEL8_ETYPE;
    sel16 = akb_pkg::SEL16_SEVEN_FIELD;
    unique case (frame_info.fmt)
      akb_pkg::KF_ARP: sel8 = akb_pkg::SEL8_ARP;
      akb_pkg::KF_IPV4_TRANSPORT: sel8 = akb_pkg::SEL8_IPV4_TRANSPORT;
      akb_pkg::KF_IPV4_MISC: sel8 = akb_pkg::SEL8_IPV4_MISC;
      akb_pkg::KF_CUSTOM_TWO: sel8 = akb_pkg::SEL8_CUSTOM_TWO;
      akb_pkg::KF_IPV6_VLAN: sel8 = akb_pkg::SEL8_IPV6_VLAN;
      akb_pkg::KF_CUSTOM_ONE: sel16 = akb_pkg::SEL16_CUSTOM_ONE;
      default: begin
        sel8 = akb_pkg::SEL8_ETYPE;
        sel16 = akb_pkg::SEL16_SEVEN_FIELD;
      end
    endcase
  end

  always_comb begin
    key_d.valid = frame_valid;
    key_d.data = '0;
    unique case (frame_info.fmt)
      akb_pkg::KF_IPV4_VLAN: begin
        key_d.size = akb_pkg::SZ_FOUR;
        key_d.data[akb_pkg::X4_FIRST] = frame_info.first_lookup;
        key_d.data[akb_pkg::X4_TAG_LSB +: akb_pkg::TAG_W] = tag_d;
      end
      akb_pkg::KF_SEVEN_FIELD, akb_pkg::KF_CUSTOM_ONE: begin
        key_d.size = akb_pkg::SZ_SIXTEEN;
        key_d.data[akb_pkg::X16_SEL_LSB +: 2] = sel16;
        key_d.data[akb_pkg::X16_FIRST] = frame_info.first_lookup;
        key_d.data[akb_pkg::X16_TAG_LSB +: akb_pkg::TAG_W] = tag_d;
        key_d.data[akb_pkg::X16_MSEL_LSB +: 2] = mode_d;
        key_d.data[akb_pkg::X16_MASK_LSB +: akb_pkg::MASK_W] = mask_d;
        key_d.data[akb_pkg::X16_MC] = mc_d;
      end
      default: begin
        key_d.size = akb_pkg::SZ_EIGHT;
        key_d.data[akb_pkg::X8_SEL_LSB +: 4] = sel8;
        key_d.data[akb_pkg::X8_FIRST] = frame_info.first_lookup;
        key_d.data[akb_pkg::X8_TAG_LSB +: akb_pkg::TAG_W] = tag_d;
        if (frame_info.fmt != akb_pkg::KF_IPV6_VLAN) begin
          key_d.data[akb_pkg::X8_MSEL_LSB +: 2] = mode_d;
          key_d.data[akb_pkg::X8_MASK_LSB +: akb_pkg::MASK_W] = mask_d;
          key_d.data[akb_pkg::X8_MC] = mc_d;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= '0;
    end else begin
      key_q <= key_d;
      if (!frame_valid) begin
        key_q.data <= '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_cnt_q <= 16'h0;
    end else if (frame_valid) begin
      key_cnt_q <= key_cnt_q + 16'h1;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign key_out = key_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mode_special: assert property (frame_valid && frame_info.cpu_injected && ctrl_q[akb_pkg::CTRL_INJ]
    |-> mode_d == akb_pkg::MM_SPECIAL) else $error("injected frame not mode 3");
  a_mode_vdev: assert property (frame_valid && is_vdev && ctrl_q[akb_pkg::CTRL_VD]
    |-> mode_d == akb_pkg::MM_SPECIAL) else $error("virtual device frame not mode 3");
  a_mode_lbk3: assert property (frame_valid && frame_info.from_loopback && ctrl_q[akb_pkg::CTRL_LBK3]
    |-> mode_d == akb_pkg::MM_SPECIAL) else $error("loopback frame not mode 3");
  a_mode_masq: assert property (mode_d == akb_pkg::MM_MASQ
    |-> is_masq && ctrl_q[akb_pkg::CTRL_MASQ]) else $error("mode 2 without masquerade");
  a_mode_prio: assert property (frame_info.from_loopback && mode_d != akb_pkg::MM_SPECIAL
    && !(is_masq && ctrl_q[akb_pkg::CTRL_MASQ]) |-> mode_d == akb_pkg::MM_LOOP)
    else $error("loopback priority wrong");
  a_key_latency: assert property (frame_valid |=> key_out.valid && key_out.size ==
    (($past(frame_info.fmt) == akb_pkg::KF_IPV4_VLAN) ? akb_pkg::SZ_FOUR :
    ($past(frame_info.fmt) inside {akb_pkg::KF_SEVEN_FIELD, akb_pkg::KF_CUSTOM_ONE}) ? akb_pkg::SZ_SIXTEEN :
    akb_pkg::SZ_EIGHT)) else $error("key not one cycle after frame");
  a_x16_size: assert property (frame_valid && frame_info.fmt == akb_pkg::KF_CUSTOM_ONE
    |=> key_out.size == akb_pkg::SZ_SIXTEEN && key_out.data[1:0] == akb_pkg::SEL16_CUSTOM_ONE)
    else $error("custom-one key wrong");
  a_etype_layout: assert property (frame_valid && frame_info.fmt == akb_pkg::KF_ETYPE
    |=> key_out.data[3:0] == akb_pkg::SEL8_ETYPE && key_out.data[4] == $past(frame_info.first_lookup))
    else $error("ethertype key layout wrong");
  a_x4_pad: assert property (key_out.valid && key_out.size == akb_pkg::SZ_FOUR
    |-> key_out.data[akb_pkg::KEY_W-1:akb_pkg::X4_TAG_LSB+akb_pkg::TAG_W] == '0)
    else $error("four-word key not padded");
  a_mc_flag: assert property (frame_valid && frame_info.fmt == akb_pkg::KF_ARP
    |=> key_out.data[akb_pkg::X8_MC] == $past(frame_info.dmac[akb_pkg::DMAC_MC_BIT]))
    else $error("multicast flag wrong");
  a_default_tag: assert property (frame_valid && !frame_info.tag_changed && frame_info.phys_port == 6'h3
    |-> tag_d == port_tag_q[3]) else $error("default policy tag not used");
  a_mode3_src: assert property (mode_d == akb_pkg::MM_SPECIAL
    |-> mask_d[9:4] == frame_info.src_port && mask_d[52] == 1'b0) else $error("mode 3 mask wrong");
  a_apb_ready: assert property (psel && !penable |=> pready) else $error("apb ready late");

  c_mode3: cover property (frame_valid && mode_d == akb_pkg::MM_SPECIAL);
  c_masq: cover property (frame_valid && mode_d == akb_pkg::MM_MASQ);
  c_x16: cover property (frame_valid && frame_info.fmt == akb_pkg::KF_SEVEN_FIELD);
endmodule : akb_key_builder
`default_nettype wire

// *** tb/akb_frame_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module akb_frame_source (
  // clock
  input wire logic pclk,
  // frames toward the key builder
  output logic frame_valid,
  output akb_pkg::akb_frame_t frame_info
);
  initial begin
    frame_valid = 1'b0;
    frame_info = '0;
  end
  // ==========================================
  // one request, taken at the following edge
  task automatic drive(input akb_pkg::akb_frame_t f);
    @(posedge pclk);
    frame_valid <= 1'b1;
    frame_info <= f;
  endtask : drive
  // idle cycles drop valid and carry the bitwise inverse of the last classification
  task automatic idle();
    @(posedge pclk);
    frame_valid <= 1'b0;
    frame_info <= ~frame_info;
  endtask : idle
endmodule : akb_frame_source
`default_nettype wire

// *** tb/akb_key_builder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module akb_key_builder_tb;
  localparam logic [5:0] PP0 = 6'h35;
  localparam logic [5:0] PP1 = 6'h36;
  localparam logic [5:0] PV0 = 6'h37;
  localparam logic [5:0] PV1 = 6'h38;
  localparam logic [2:0] MQA = 3'h1;
  localparam logic [3:0] S8 [0:6] = '{4'h0, 4'h0, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_valid, pend;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  akb_pkg::akb_frame_t frame_info;
  akb_pkg::akb_key_t key_out, pend_exp;
  logic [7:0] tags [0:52];
  logic [3:0] ctrl;
  int mismatches, total_checks, built;
  akb_key_builder #(.PROC_PORT0(PP0), .PROC_PORT1(PP1), .VDEV_PORT0(PV0), .VDEV_PORT1(PV1),
    .MASQ_INJECT_ACT(MQA)) akb_key_builder_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid), .frame_info(frame_info),
    .key_out(key_out));
  akb_frame_source akb_frame_source_i (.pclk(pclk), .frame_valid(frame_valid), .frame_info(frame_info));
  // ==========================================
  // checking and closing
  task automatic check(input string what, input logic [578:0] exp, input logic [578:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // apb master
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    if (n >= 16) begin
      check("pready", 579'(1), 579'(0));
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check("prdata", 579'(x), 579'(r));
    check("pslverr", 579'(xe), 579'(e));
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    check("pslverr", 579'(xe), 579'(e));
  endtask : wr
  // ==========================================
  // expected key
  function automatic logic [52:0] hot(input logic [5:0] p);
    hot = (p < 6'd53) ? 53'h1 << p : 53'h0;
  endfunction : hot
  function automatic akb_pkg::akb_key_t exp_key(input akb_pkg::akb_frame_t f, input logic [3:0] c);
    akb_pkg::akb_key_t k;
    logic masq, m3;
    logic [1:0] m;
    logic [52:0] mk;
    logic [7:0] t;
    masq = (f.dst_inject && f.src_port != f.phys_port) || f.pipe_act == MQA;
    m3 = (f.cpu_injected && c[1]) || ((f.phys_port == PV0 || f.phys_port == PV1) && c[2]) || (f.from_loopback && c[3]);
    m = m3 ? 2'h3 : (masq && c[0]) ? 2'h2 : f.from_loopback ? 2'h1 : 2'h0;
    mk = (m == 2'h0) ? hot(f.phys_port) : (m == 2'h1) ? hot(f.loop_port) : hot(f.src_port);
    if (m == 2'h3) mk = {1'b0, f.pipe_act, f.pipe_pt, 34'h0, f.src_port, f.phys_port == PV1,
      f.phys_port == PV0, f.phys_port == PP1, f.phys_port == PP0};
    t = f.tag_changed ? f.tag : tags[f.phys_port];
    k = '0;
    k.valid = 1'b1;
    case (f.fmt)
      akb_pkg::KF_IPV4_VLAN: begin
        k.size = akb_pkg::SZ_FOUR;
        k.data[8:0] = {t, f.first_lookup};
      end
      akb_pkg::KF_SEVEN_FIELD, akb_pkg::KF_CUSTOM_ONE: begin
        k.size = akb_pkg::SZ_SIXTEEN;
        k.data[66:0] = {f.dmac[40], mk, m, t, f.first_lookup, (f.fmt == akb_pkg::KF_SEVEN_FIELD) ? 2'h1 : 2'h2};
      end
      default: begin
        k.size = akb_pkg::SZ_EIGHT;
        k.data[68:0] = {f.dmac[40], mk, m, t, f.first_lookup, S8[f.fmt]};
        if (f.fmt == akb_pkg::KF_IPV6_VLAN) k.data[68:13] = '0;
      end
    endcase
    return k;
  endfunction : exp_key
  function automatic akb_pkg::akb_frame_t mk_frame(input int k, input int c);
    akb_pkg::akb_frame_t f;
    f = '0;
    f.fmt = akb_pkg::akb_fmt_t'((k + c) % 9);
    f.first_lookup = k[0];
    f.pipe_pt = 5'(k * 7 + 3);
    f.pipe_act = 3'(k + c + 2);
    f.dmac = 48'h0a0b0c0d0e0f;
    f.dmac[40] = k[1] ^ c[0];
    f.tag = 8'(k * 37 + 1);
    f.tag_changed = 1'b1;
    case (k % 6)
      0: f.tag_changed = 1'b0;
      1: f = {f.fmt, f.first_lookup, f.tag_changed, f.tag, PV1, 6'd17, 6'd9, 3'b001, f.pipe_pt, f.pipe_act, f.dmac};
      2: f = {f.fmt, f.first_lookup, 1'b0, f.tag, 6'd4, 6'd12, 6'd0, 3'b100, f.pipe_pt, f.pipe_act, f.dmac};
      3: f = {f.fmt, f.first_lookup, f.tag_changed, f.tag, PP0, 6'd20, 6'd0, 3'b000, f.pipe_pt, MQA, f.dmac};
      4: f = {f.fmt, f.first_lookup, f.tag_changed, f.tag, PP1, PP1, 6'd0, 3'b110, f.pipe_pt, f.pipe_act, f.dmac};
      default: f = {f.fmt, f.first_lookup, f.tag_changed, f.tag, PV0, 6'd52, 6'd41, 3'b101, f.pipe_pt, f.pipe_act, f.dmac};
    endcase
    if (k % 6 == 0) f.phys_port = 6'd3;
    return f;
  endfunction : mk_frame
  // ==========================================
  // key path driver, keys checked one cycle after being driven
  task automatic push(input akb_pkg::akb_frame_t f);
    akb_frame_source_i.drive(f);
    #1;
    if (pend) check("key_out", pend_exp, key_out);
    pend = 1'b1;
    pend_exp = exp_key(f, ctrl);
    built++;
  endtask : push
  task automatic flush();
    akb_frame_source_i.idle();
    #1;
    check("key_out", pend_exp, key_out);
    pend = 1'b0;
    @(posedge pclk);
    #1;
    check("key_idle", 579'(0), 579'({key_out.valid, key_out.data}));
  endtask : flush
  // ==========================================
  // clock, watchdog, tests
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    check("watchdog", 579'(1), 579'(0));
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pend, ctrl} = '0;
    foreach (tags[i]) tags[i] = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check("key_reset", 579'(0), key_out);
    rd(akb_pkg::REG_CTRL, 32'h0, 1'b0);
    rd(akb_pkg::REG_TAG_DATA, 32'h0, 1'b0);
    wr(12'h010, 32'hffffffff, 1'b1);
    rd(12'h010, 32'h0, 1'b1);
    rd(akb_pkg::REG_CTRL, 32'h0, 1'b0);
    for (int p = 3; p <= 53; p++) begin
      if (p > 4 && p < 52) continue;
      wr(akb_pkg::REG_TAG_IDX, 32'(p), 1'b0);
      wr(akb_pkg::REG_TAG_DATA, 32'(p ^ 8'h5a), 1'b0);
      if (p < 53) tags[p] = 8'(p ^ 8'h5a);
      rd(akb_pkg::REG_TAG_DATA, (p < 53) ? 32'(p ^ 8'h5a) : 32'h0, 1'b0);
    end
    for (int c = 0; c < 16; c++) begin
      wr(akb_pkg::REG_CTRL, 32'(c), 1'b0);
      rd(akb_pkg::REG_CTRL, 32'(c), 1'b0);
      ctrl = 4'(c);
      for (int k = 0; k < 9; k++) push(mk_frame(k, c));
      flush();
    end
    wr(akb_pkg::REG_STATUS, 32'h0000ffff, 1'b0);
    rd(akb_pkg::REG_STATUS, 32'(built), 1'b0);
    tally_and_finish();
  end
endmodule : akb_key_builder_tb
`default_nettype wire
